// ### include/reload_timer_pkg.sv
// constants shared by the reload timer readback block
package reload_timer_pkg;

  // ==========================================================
  // bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W  = 16;

  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_CTRL     = 8'h80;
  localparam logic [7:0] IDX_CNT_HIGH = 8'h82;
  localparam logic [7:0] IDX_CNT_LOW  = 8'h84;

  // ==========================================================
  // control register fields
  localparam int unsigned CTRL_RUN_BIT      = 0;
  localparam int unsigned CTRL_RESTART_BIT  = 1;
  localparam int unsigned CTRL_PERIODIC_BIT = 2;
  localparam int unsigned CTRL_W            = 3;

  // ==========================================================
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RESET  = 3'h0;
  localparam logic [CNT_W-1:0]  COUNT_RESET = 16'h0000;
  localparam logic [7:0]        BYTE_RESET  = 8'h00;

  // byte address of a register index
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = {2'h0, idx, 2'h0};
  endfunction

  // true when the bus address selects the given register
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [7:0]        idx);
    addr_hit = (addr == reg_addr(idx));
  endfunction

endpackage

// ### include/count_capture_if.sv
// carrier between the timer core and the high byte holding latch
interface count_capture_if;
  import reload_timer_pkg::*;

  logic [CNT_W-1:0] count_value;
  logic             capture;
  logic [7:0]       held_high;

  modport core  (output count_value, output capture, input held_high);
  modport latch (input count_value, input capture, output held_high);
endinterface

// ### rtl/count_high_latch.sv
// holding latch for the upper count byte
module count_high_latch
  import reload_timer_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // core side
  count_capture_if.latch  cap
);
  import reload_timer_pkg::*;

  logic [7:0] held_reg;
  logic [7:0] held_next;

  // ==========================================================
  // capture on low byte read
  always_comb begin
    held_next = held_reg;
    if (cap.capture) begin
      held_next = cap.count_value[15:8];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      held_reg <= BYTE_RESET;
    end else begin
      held_reg <= held_next;
    end
  end

  assign cap.held_high = held_reg;

endmodule

// ### rtl/reload_timer_count_readback.sv
// reload timer core with apb register slave and count readback
//
// Overview of operation
// - restart disabled means no self reload
// - restart enabled loads reload value on restart
// - run enable gates counting, a restart write loads the counter even when stopped
// - low count read returns count bits 7..0
// - count reads never disturb timer operation
// - low read captures upper byte in latch
// - high byte maps to count bits 15..8
// - count and reload registers share addresses
// - periodic mode with restart set reloads at every end of count
// - restart write loads counter on the edge after the write is taken
// - reload value built from two bytes
//
// Our own choice: the APB interface to the registers.
module reload_timer_count_readback
  import reload_timer_pkg::*;
(
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        reset,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [reload_timer_pkg::ADDR_W-1:0] paddr,
  input  wire logic [reload_timer_pkg::DATA_W-1:0] pwdata,
  output logic      [reload_timer_pkg::DATA_W-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr,
  // timer status
  output logic                             end_of_count
);
  import reload_timer_pkg::*;

  count_capture_if cap ();

  logic [CTRL_W-1:0] ctrl_reg;
  logic [CTRL_W-1:0] ctrl_next;
  logic [7:0]        reload_low_reg;
  logic [7:0]        reload_low_next;
  logic [7:0]        reload_high_reg;
  logic [7:0]        reload_high_next;
  logic              load_pend_reg;
  logic              load_pend_next;
  logic [CNT_W-1:0]  count_reg;
  logic [CNT_W-1:0]  count_next;
  logic              eoc_reg;
  logic              eoc_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic              err_reg;
  logic              err_next;

  logic              setup;
  logic              access;
  logic              hit_ctrl;
  logic              hit_high;
  logic              hit_low;
  logic              mapped;
  logic              wr_take;
  logic [CNT_W-1:0]  reload_value;
  logic              run_en;
  logic              restart_en;
  logic              periodic;

  // ==========================================================
  // bus decode
  assign setup    = psel & ~penable;
  assign access   = psel & penable;
  assign hit_ctrl = addr_hit(paddr, IDX_CTRL);
  assign hit_high = addr_hit(paddr, IDX_CNT_HIGH);
  assign hit_low  = addr_hit(paddr, IDX_CNT_LOW);
  assign mapped   = hit_ctrl | hit_high | hit_low;
  assign wr_take  = access & pwrite & mapped;

  assign pready  = 1'b1;
  assign prdata  = rdata_reg;
  assign pslverr = err_reg & access;

  assign reload_value = {reload_high_reg, reload_low_reg};
  assign run_en       = ctrl_reg[CTRL_RUN_BIT];
  assign restart_en   = ctrl_reg[CTRL_RESTART_BIT];
  assign periodic     = ctrl_reg[CTRL_PERIODIC_BIT];

  // ==========================================================
  // read data and capture, taken at the setup edge
  always_comb begin
    rdata_next  = rdata_reg;
    err_next    = err_reg;
    cap.capture = 1'b0;
    if (setup) begin
      err_next   = ~mapped;
      rdata_next = '0;
      if (!pwrite) begin
        if (hit_ctrl) begin
          rdata_next[CTRL_W-1:0] = ctrl_reg;
        end else if (hit_low) begin
          rdata_next[7:0] = count_reg[7:0];
          cap.capture = 1'b1;
        end else if (hit_high) begin
          rdata_next[7:0] = cap.held_high;
        end
      end
    end
  end

  assign cap.count_value = count_reg;

  count_high_latch u_latch (
    .sys_clk (sys_clk),
    .reset   (reset),
    .cap     (cap)
  );

  // ==========================================================
  // register writes and counter
  always_comb begin
    ctrl_next        = ctrl_reg;
    reload_low_next  = reload_low_reg;
    reload_high_next = reload_high_reg;
    load_pend_next   = 1'b0;
    count_next       = count_reg;
    eoc_next         = 1'b0;

    if (load_pend_reg) begin
      count_next = reload_value;
    end else if (run_en) begin
      if (count_reg == COUNT_RESET) begin
        eoc_next = 1'b1;
        if (restart_en) begin
          count_next = reload_value;
          if (!periodic) begin
            ctrl_next[CTRL_RESTART_BIT] = 1'b0;
          end
        end
      end else begin
        count_next = count_reg - 16'h0001;
      end
    end

    // software write wins over hardware clear
    if (wr_take) begin
      if (hit_low) begin
        reload_low_next = pwdata[7:0];
      end
      if (hit_high) begin
        reload_high_next = pwdata[7:0];
      end
      if (hit_ctrl) begin
        ctrl_next      = pwdata[CTRL_W-1:0];
        load_pend_next = pwdata[CTRL_RESTART_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl_reg        <= CTRL_RESET;
      reload_low_reg  <= BYTE_RESET;
      reload_high_reg <= BYTE_RESET;
      load_pend_reg   <= 1'b0;
      count_reg       <= COUNT_RESET;
      eoc_reg         <= 1'b0;
      rdata_reg       <= '0;
      err_reg         <= 1'b0;
    end else begin
      ctrl_reg        <= ctrl_next;
      reload_low_reg  <= reload_low_next;
      reload_high_reg <= reload_high_next;
      load_pend_reg   <= load_pend_next;
      count_reg       <= count_next;
      eoc_reg         <= eoc_next;
      rdata_reg       <= rdata_next;
      err_reg         <= err_next;
    end
  end

  assign end_of_count = eoc_reg;

endmodule

// ### sim/reload_timer_count_readback_assertions.sv
// checker for the reload timer readback bus and status ports
module reload_timer_count_readback_assertions
  import reload_timer_pkg::*;
(
  // clock and reset
  input wire logic                                  sys_clk,
  input wire logic                                  reset,
  // apb and status
  input wire logic                                  psel,
  input wire logic                                  penable,
  input wire logic                                  pwrite,
  input wire logic [reload_timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [reload_timer_pkg::DATA_W-1:0] pwdata,
  input wire logic [reload_timer_pkg::DATA_W-1:0] prdata,
  input wire logic                                  pready,
  input wire logic                                  pslverr,
  input wire logic                                  end_of_count
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic run_q;
  wire logic hit_ct = addr_hit(paddr, IDX_CTRL);
  wire logic hit_cn = addr_hit(paddr, IDX_CNT_LOW) || addr_hit(paddr, IDX_CNT_HIGH);
  // ==========================================
  // run bit as last written by software
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) run_q <= 1'b0;
    else if (psel && penable && pwrite && hit_ct) run_q <= pwdata[CTRL_RUN_BIT];
  end
  sequence setup_s; psel && !penable; endsequence
  sequence rd_cnt_s; setup_s ##0 (!pwrite && hit_cn); endsequence
  // ==========================================
  // properties
  a_err_unmapped: assert property (setup_s ##0 !(hit_ct || hit_cn) |=> pslverr)
    else $error("no error on unmapped access");
  a_err_mapped: assert property (setup_s ##0 (hit_ct || hit_cn) |=> !pslverr)
    else $error("error on mapped access");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  a_count_byte: assert property (rd_cnt_s |=> prdata[31:8] == 24'h0)
    else $error("count read wider than a byte");
  a_ctrl_width: assert property (setup_s ##0 (!pwrite && hit_ct) |=> prdata[31:3] == 29'h0)
    else $error("control read wider than its fields");
  a_data_holds: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data changed outside setup");
  a_ready_high: assert property (psel && penable |-> pready)
    else $error("access not answered at once");
  a_stopped_quiet: assert property (!run_q [*2] |-> !end_of_count)
    else $error("end of count while stopped");
endmodule

bind reload_timer_count_readback reload_timer_count_readback_assertions chk (
  .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .end_of_count(end_of_count));

// ### sim/reload_timer_count_readback_tb.sv
// self-checking bench for the reload timer readback block
module reload_timer_count_readback_tb import reload_timer_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [32:0] SKIP = 33'h1_ffff_ffff;
  localparam logic [11:0] A_LO = 12'h210, A_HI = 12'h208, A_CT = 12'h200;
  logic        sys_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, end_of_count;
  logic [32:0] q[$];
  logic [15:0] v, p;
  int          n_errors = 0, n_tests = 0, cycles = 0, n, seed = 32'ha97e9de4;
  always #10 sys_clk = ~sys_clk;
  reload_timer_count_readback uut (.sys_clk(sys_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .end_of_count(end_of_count));
  // ==========================================
  // tasks
  task automatic give_verdict();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string nm, input logic [32:0] s, input logic [32:0] e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] b,
                     input logic [32:0] e);
    logic [31:0] r;
    r = $random(seed);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {r[31:8], b};
    if (!w) q.push_back(e);
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] b); apb(1'b1, a, b, 33'h0); endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] b, input logic e = 1'b0);
    apb(1'b0, a, 8'h0, {e, 24'h0, b});
  endtask
  task automatic wait_eoc(output int c);
    c = 0;
    do begin @(posedge sys_clk); c++; end while (end_of_count !== 1'b1 && c < 1000);
  endtask
  // ==========================================
  // read monitor and timeout
  // read data taken at the edge where pready is sampled high
  always @(posedge sys_clk) begin
    if (psel && penable && pready && !pwrite && q.size() > 0) begin
      if (q[0] !== SKIP) check("read", {pslverr, prdata}, q.pop_front());
      else q.pop_front();
    end
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin n_errors++; give_verdict(); end
  end
  // ==========================================
  // scenarios
  initial begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd(A_LO, 8'h0); rd(A_HI, 8'h0); rd(A_CT, 8'h0);
    rd(12'h20c, 8'h0, 1'b1); wr(12'h20c, 8'hff); rd(A_CT, 8'h0);
    v = $random(seed);
    wr(A_HI, v[15:8]); wr(A_LO, v[7:0]); rd(A_LO, 8'h0);
    wr(A_CT, 8'h02); rd(A_LO, v[7:0]); rd(A_HI, v[15:8]);
    wr(A_LO, ~v[7:0]); wr(A_HI, ~v[15:8]); rd(A_HI, v[15:8]);
    // low byte read after high byte
    rd(A_LO, v[7:0]);
    p = {12'h0, v[3:0]} | 16'h0008;
    wr(A_HI, 8'h00); wr(A_LO, p[7:0]); wr(A_CT, 8'h07);
    fork
      begin wait_eoc(n); wait_eoc(n); check("period", 33'(n), 33'(p) + 33'h1); end
      repeat (3) begin apb(1'b0, A_LO, 8'h0, SKIP); apb(1'b0, A_HI, 8'h0, SKIP); end
    join
    wr(A_CT, 8'h03); wait_eoc(n); check("one shot", 33'(n < 100), 33'h1);
    repeat (60) @(posedge sys_clk);
    rd(A_CT, 8'h01); rd(A_LO, 8'h0); rd(A_HI, 8'h0);
    wr(A_CT, 8'h02); rd(A_LO, p[7:0]);
    give_verdict();
  end
endmodule
